// ==== logic/clc_cfg_if.sv ====
// Purpose: carries held register fields from the register bank to the shaper
// Assumes: both ends in the CLK_IN domain
// Notes: fields are already registered at the source
`timescale 1ns/10ps
interface clc_cfg_if;
  logic [7:0] subcarrier_phase;
  logic [8:0] blue_diff_gain;
  logic [8:0] red_diff_gain;
  logic [5:0] black_level;
  logic [5:0] blank_level;
  logic [5:0] vbi_blank_level;
  logic [1:0] cross_color_select;

  modport src (output subcarrier_phase, output blue_diff_gain, output red_diff_gain,
               output black_level, output blank_level, output vbi_blank_level,
               output cross_color_select);
  modport snk (input subcarrier_phase, input blue_diff_gain, input red_diff_gain,
               input black_level, input blank_level, input vbi_blank_level,
               input cross_color_select);
endinterface : clc_cfg_if

// ==== logic/clc_pkg.sv ====
// Purpose: constants for the chroma and level control registers
// Assumes: byte-wide subaddressed register port, single clock
// Notes: field positions and reset values are named once here
// Notes on behaviour
// - subcarrier phase turns by register value in 360/256 degree steps, zero after reset
// - blue gain zero removes U; 118 nominal at 92.5 IRE, 125 at 100 IRE
// - red gain zero removes V; 165 nominal at 92.5 IRE, 175 at 100 IRE
// - at 140 IRE sync, black level is field times 2/6.29 plus 28.9
// - at 143 IRE sync, black level is field times 2/6.18 plus 26.5
// - at 140 IRE sync, blanking level is field times 2/6.29 plus 25.4
// - at 143 IRE sync, blanking level is field times 2/6.18 plus 25.9
// - blanking level field resets to 35h
// - two-bit selector picks cross-colour filter; 00 off, 01..11 filters one to three
// - separate six-bit blanking level applies during vertical blanking
package clc_pkg;
  localparam logic [7:0] PHASE_ADDR      = 8'h5A;
  localparam logic [7:0] U_GAIN_LOW_ADDR = 8'h5B;
  localparam logic [7:0] V_GAIN_LOW_ADDR = 8'h5C;
  localparam logic [7:0] U_TOP_BLK_ADDR  = 8'h5D;
  localparam logic [7:0] V_TOP_BLN_ADDR  = 8'h5E;
  localparam logic [7:0] XCR_VBI_ADDR    = 8'h5F;

  localparam int GAIN_TOP_BIT  = 7;
  localparam int RESERVED_BIT  = 6;
  localparam int LEVEL_MSB     = 5;
  localparam int XCR_MSB       = 7;
  localparam int XCR_LSB       = 6;
  localparam int GAIN_SHIFT    = 7;

  localparam logic [7:0] PHASE_RESET     = 8'h00;
  localparam logic [8:0] GAIN_RESET      = 9'h000;
  localparam logic [5:0] BLACK_RESET     = 6'h00;
  localparam logic [5:0] BLANK_RESET     = 6'h35;
  localparam logic [5:0] VBI_BLANK_RESET = 6'h00;
  localparam logic [1:0] XCR_RESET       = 2'h0;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;
endpackage : clc_pkg

// ==== logic/clc_shaper.sv ====
// Purpose: applies gains, phase offset and level choice to each sample
// Assumes: one sample per asserted valid, fields stable or changing between samples
// Notes: every output is registered, one cycle after the sample is taken
`timescale 1ns/10ps
module clc_shaper (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  clc_cfg_if.snk                 cfg,
  input  wire logic              valid_in,
  input  wire logic signed [7:0] u_in,
  input  wire logic signed [7:0] v_in,
  input  wire logic [7:0]        phase_in,
  input  wire logic              blank_in,
  input  wire logic              vbi_in,
  output logic                   valid_out,
  output logic signed [9:0]      u_out,
  output logic signed [9:0]      v_out,
  output logic [7:0]             phase_out,
  output logic [5:0]             level_out,
  output logic [1:0]             xcr_out
);
  logic signed [16:0] u_prod;
  logic signed [16:0] v_prod;
  logic               next_valid;
  logic signed [9:0]  next_u;
  logic signed [9:0]  next_v;
  logic [7:0]         next_phase;
  logic [5:0]         next_level;
  logic [1:0]         next_xcr;

  always_comb begin
    // gain of zero gives a zero product, so the colour term vanishes
    u_prod     = u_in * $signed(cfg.blue_diff_gain);
    v_prod     = v_in * $signed(cfg.red_diff_gain);
    next_u     = u_prod[clc_pkg::GAIN_SHIFT +: 10];
    next_v     = v_prod[clc_pkg::GAIN_SHIFT +: 10];
    // 8-bit wrap gives the 360/256 degree step, burst included
    next_phase = phase_in + cfg.subcarrier_phase;
    if (vbi_in) begin
      next_level = cfg.vbi_blank_level;
    end else if (blank_in) begin
      next_level = cfg.blank_level;
    end else begin
      next_level = cfg.black_level;
    end
    next_xcr   = cfg.cross_color_select;
    next_valid = valid_in;
    // hold u, v, phase and level between samples so idle cycles show the last result
    if (!valid_in) begin
      next_u     = u_out;
      next_v     = v_out;
      next_phase = phase_out;
      next_level = level_out;
    end
  end

  // new field values reach the very next sample taken
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_out <= 1'b0;
      u_out     <= 10'sh000;
      v_out     <= 10'sh000;
      phase_out <= 8'h00;
      level_out <= 6'h00;
      xcr_out   <= 2'h0;
    end else begin
      valid_out <= next_valid;
      u_out     <= next_u;
      v_out     <= next_v;
      phase_out <= next_phase;
      level_out <= next_level;
      xcr_out   <= next_xcr;
    end
  end
endmodule : clc_shaper

// ==== logic/clc_top.sv ====
// Purpose: chroma phase, colour gain and level register bank with its shaper
// Assumes: byte register port already decoded from the control bus
// Notes: bit 6 of the black and blanking level registers (5Dh, 5Eh) is not stored and reads zero
`timescale 1ns/10ps
module clc_top (
  input  wire logic              CLK_IN,
  input  wire logic              RST_IN,
  input  wire logic              REG_WR_IN,
  input  wire logic              REG_RD_IN,
  input  wire logic [7:0]        REG_ADDR_IN,
  input  wire logic [7:0]        REG_WDATA_IN,
  output logic [7:0]             REG_RDATA_OUT,
  input  wire logic              SAMPLE_VALID_IN,
  input  wire logic signed [7:0] U_IN,
  input  wire logic signed [7:0] V_IN,
  input  wire logic [7:0]        SC_PHASE_IN,
  input  wire logic              BLANK_IN,
  input  wire logic              VBI_IN,
  output logic                   SAMPLE_VALID_OUT,
  output logic signed [9:0]      U_OUT,
  output logic signed [9:0]      V_OUT,
  output logic [7:0]             SC_PHASE_OUT,
  output logic [5:0]             LEVEL_OUT,
  output logic [1:0]             XCR_SEL_OUT
);
  clc_cfg_if cfg ();

  logic [7:0] subcarrier_phase;
  logic [8:0] blue_diff_gain;
  logic [8:0] red_diff_gain;
  logic [5:0] black_level;
  logic [5:0] blank_level;
  logic [5:0] vbi_blank_level;
  logic [1:0] cross_color_select;
  logic [7:0] next_subcarrier_phase;
  logic [8:0] next_blue_diff_gain;
  logic [8:0] next_red_diff_gain;
  logic [5:0] next_black_level;
  logic [5:0] next_blank_level;
  logic [5:0] next_vbi_blank_level;
  logic [1:0] next_cross_color_select;
  logic [7:0] next_rdata;

  always_comb begin
    next_subcarrier_phase   = subcarrier_phase;
    next_blue_diff_gain     = blue_diff_gain;
    next_red_diff_gain      = red_diff_gain;
    next_black_level        = black_level;
    next_blank_level        = blank_level;
    next_vbi_blank_level    = vbi_blank_level;
    next_cross_color_select = cross_color_select;
    if (REG_WR_IN) begin
      if (REG_ADDR_IN == clc_pkg::PHASE_ADDR) begin
        next_subcarrier_phase = REG_WDATA_IN;
      end else if (REG_ADDR_IN == clc_pkg::U_GAIN_LOW_ADDR) begin
        next_blue_diff_gain[7:0] = REG_WDATA_IN;
      end else if (REG_ADDR_IN == clc_pkg::V_GAIN_LOW_ADDR) begin
        next_red_diff_gain[7:0] = REG_WDATA_IN;
      end else if (REG_ADDR_IN == clc_pkg::U_TOP_BLK_ADDR) begin
        // bit 6 is dropped; software keeps it zero anyway
        next_blue_diff_gain[8] = REG_WDATA_IN[clc_pkg::GAIN_TOP_BIT];
        next_black_level       = REG_WDATA_IN[clc_pkg::LEVEL_MSB:0];
      end else if (REG_ADDR_IN == clc_pkg::V_TOP_BLN_ADDR) begin
        next_red_diff_gain[8] = REG_WDATA_IN[clc_pkg::GAIN_TOP_BIT];
        next_blank_level      = REG_WDATA_IN[clc_pkg::LEVEL_MSB:0];
      end else if (REG_ADDR_IN == clc_pkg::XCR_VBI_ADDR) begin
        next_cross_color_select = REG_WDATA_IN[clc_pkg::XCR_MSB:clc_pkg::XCR_LSB];
        next_vbi_blank_level    = REG_WDATA_IN[clc_pkg::LEVEL_MSB:0];
      end
    end
  end

  // field registers, updated on the write edge itself
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      subcarrier_phase   <= clc_pkg::PHASE_RESET;
      blue_diff_gain     <= clc_pkg::GAIN_RESET;
      red_diff_gain      <= clc_pkg::GAIN_RESET;
      black_level        <= clc_pkg::BLACK_RESET;
      blank_level        <= clc_pkg::BLANK_RESET;
      vbi_blank_level    <= clc_pkg::VBI_BLANK_RESET;
      cross_color_select <= clc_pkg::XCR_RESET;
    end else begin
      subcarrier_phase   <= next_subcarrier_phase;
      blue_diff_gain     <= next_blue_diff_gain;
      red_diff_gain      <= next_red_diff_gain;
      black_level        <= next_black_level;
      blank_level        <= next_blank_level;
      vbi_blank_level    <= next_vbi_blank_level;
      cross_color_select <= next_cross_color_select;
    end
  end

  // read data is registered so the port comes from a flip-flop; it holds between reads
  always_comb begin
    next_rdata = REG_RDATA_OUT;
    if (REG_RD_IN) begin
      if (REG_ADDR_IN == clc_pkg::PHASE_ADDR) begin
        next_rdata = subcarrier_phase;
      end else if (REG_ADDR_IN == clc_pkg::U_GAIN_LOW_ADDR) begin
        next_rdata = blue_diff_gain[7:0];
      end else if (REG_ADDR_IN == clc_pkg::V_GAIN_LOW_ADDR) begin
        next_rdata = red_diff_gain[7:0];
      end else if (REG_ADDR_IN == clc_pkg::U_TOP_BLK_ADDR) begin
        next_rdata = {blue_diff_gain[8], 1'b0, black_level};
      end else if (REG_ADDR_IN == clc_pkg::V_TOP_BLN_ADDR) begin
        next_rdata = {red_diff_gain[8], 1'b0, blank_level};
      end else if (REG_ADDR_IN == clc_pkg::XCR_VBI_ADDR) begin
        next_rdata = {cross_color_select, vbi_blank_level};
      end else begin
        next_rdata = clc_pkg::UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= 8'h00;
    end else begin
      REG_RDATA_OUT <= next_rdata;
    end
  end

  assign cfg.subcarrier_phase   = subcarrier_phase;
  assign cfg.blue_diff_gain     = blue_diff_gain;
  assign cfg.red_diff_gain      = red_diff_gain;
  assign cfg.black_level        = black_level;
  assign cfg.blank_level        = blank_level;
  assign cfg.vbi_blank_level    = vbi_blank_level;
  assign cfg.cross_color_select = cross_color_select;

  clc_shaper u_shaper (
    .clk_in    (CLK_IN),
    .rst_in    (RST_IN),
    .cfg       (cfg),
    .valid_in  (SAMPLE_VALID_IN),
    .u_in      (U_IN),
    .v_in      (V_IN),
    .phase_in  (SC_PHASE_IN),
    .blank_in  (BLANK_IN),
    .vbi_in    (VBI_IN),
    .valid_out (SAMPLE_VALID_OUT),
    .u_out     (U_OUT),
    .v_out     (V_OUT),
    .phase_out (SC_PHASE_OUT),
    .level_out (LEVEL_OUT),
    .xcr_out   (XCR_SEL_OUT)
  );
endmodule : clc_top

// ==== testbench/clc_asserts.sv ====
// Purpose: port checks for clc_top
// Assumes: one clock, async active-high reset
// Notes: field values are learnt only from writes seen at the ports
`timescale 1ns/10ps
module clc_asserts (
  input wire logic       CLK_IN,
  input wire logic       RST_IN,
  input wire logic       REG_WR_IN,
  input wire logic       REG_RD_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic       SAMPLE_VALID_IN,
  input wire logic [7:0] SC_PHASE_IN,
  input wire logic       VBI_IN,
  input wire logic       SAMPLE_VALID_OUT,
  input wire logic [7:0] SC_PHASE_OUT,
  input wire logic [5:0] LEVEL_OUT,
  input wire logic [1:0] XCR_SEL_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  wire wr_ph  = REG_WR_IN && REG_ADDR_IN == 8'h5A;
  wire wr_xcr = REG_WR_IN && REG_ADDR_IN == 8'h5F;
  a_valid_follow: assert property (SAMPLE_VALID_IN |=> SAMPLE_VALID_OUT) else $error("valid lost");
  a_valid_drop: assert property (!SAMPLE_VALID_IN |=> !SAMPLE_VALID_OUT) else $error("stray valid");
  a_sample_hold: assert property (!SAMPLE_VALID_IN |=> $stable(LEVEL_OUT) && $stable(SC_PHASE_OUT))
    else $error("output moved without sample");
  a_unmapped_zero: assert property (REG_RD_IN && (REG_ADDR_IN < 8'h5A || REG_ADDR_IN > 8'h5F)
    |=> REG_RDATA_OUT == 8'h00) else $error("unmapped read not zero");
  a_bit6_zero: assert property (REG_RD_IN && (REG_ADDR_IN == 8'h5D || REG_ADDR_IN == 8'h5E)
    |=> !REG_RDATA_OUT[6]) else $error("bit 6 reads one");
  a_rdata_hold: assert property (!REG_RD_IN |=> $stable(REG_RDATA_OUT)) else $error("read data moved");
  a_phase_add: assert property (wr_ph ##1 (SAMPLE_VALID_IN && !wr_ph)
    |=> SC_PHASE_OUT == 8'($past(SC_PHASE_IN) + $past(REG_WDATA_IN, 2))) else $error("phase sum wrong");
  a_vbi_level: assert property (wr_xcr ##1 (SAMPLE_VALID_IN && VBI_IN && !REG_WR_IN)
    |=> LEVEL_OUT == $past(REG_WDATA_IN[5:0], 2)) else $error("vbi level wrong");
  a_xcr_follow: assert property (wr_xcr ##1 !wr_xcr |=> XCR_SEL_OUT == $past(REG_WDATA_IN[7:6], 2))
    else $error("filter select wrong");
  c_phase: cover property (wr_ph ##1 SAMPLE_VALID_IN);
  c_vbi: cover property (SAMPLE_VALID_IN && VBI_IN);
  c_unmapped: cover property (REG_RD_IN && REG_ADDR_IN > 8'h5F);
endmodule : clc_asserts
bind clc_top clc_asserts chk_u (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .SAMPLE_VALID_IN(SAMPLE_VALID_IN), .SC_PHASE_IN(SC_PHASE_IN), .VBI_IN(VBI_IN),
  .SAMPLE_VALID_OUT(SAMPLE_VALID_OUT), .SC_PHASE_OUT(SC_PHASE_OUT), .LEVEL_OUT(LEVEL_OUT),
  .XCR_SEL_OUT(XCR_SEL_OUT));

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for clc_top
// Assumes: a sample may follow a write on the very next edge
// Notes: gain results use the shift of 7 chosen for the shaper
`timescale 1ns/10ps
module tb;
  logic              clk = 1'b0, rst = 1'b1, wr = 1'b0, rd_s = 1'b0, vld = 1'b0, bl = 1'b0, vb = 1'b0, vo_v;
  logic [7:0]        adr = 8'h00, wd = 8'h00, ph = 8'h00, rdat, pho, d;
  logic signed [7:0] u = 8'h00, v = 8'h00;
  logic signed [9:0] uo, vo;
  logic [5:0]        lvl;
  logic [1:0]        xcr;
  int                mismatches = 0, n_tests = 0, cyc = 0;
  always #4 clk = ~clk;
  clc_top dut_u (.CLK_IN(clk), .RST_IN(rst), .REG_WR_IN(wr), .REG_RD_IN(rd_s), .REG_ADDR_IN(adr),
    .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdat), .SAMPLE_VALID_IN(vld), .U_IN(u), .V_IN(v), .SC_PHASE_IN(ph),
    .BLANK_IN(bl), .VBI_IN(vb), .SAMPLE_VALID_OUT(vo_v), .U_OUT(uo), .V_OUT(vo), .SC_PHASE_OUT(pho),
    .LEVEL_OUT(lvl), .XCR_SEL_OUT(xcr));
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [7:0] x);
    @(posedge clk) begin wr <= 1'b1; adr <= a; wd <= x; end
    @(posedge clk) wr <= 1'b0;
  endtask : wrr
  task automatic rdr(input logic [7:0] a, output logic [7:0] x);
    @(posedge clk) begin rd_s <= 1'b1; adr <= a; end
    @(posedge clk) rd_s <= 1'b0;
    #1 x = rdat;
  endtask : rdr
  // starts at once so a sample can land on the edge right after a write
  task automatic smp(input logic [7:0] uu, input logic [7:0] vv, input logic [7:0] p, input logic b, input logic q);
    vld <= 1'b1; u <= uu; v <= vv; ph <= p; bl <= b; vb <= q;
    @(posedge clk) vld <= 1'b0;
    #1;
  endtask : smp
  task automatic t_regs;
    logic [7:0] e [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h35, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rdr(8'h5A + 8'(i), d);
      chk(10'(d), 10'(e[i]));
      // bit 6 of the two level registers is always written as zero
      wrr(8'h5A + 8'(i), (i == 3 || i == 4) ? 8'hBF : 8'hFF);
      rdr(8'h5A + 8'(i), d);
      chk(10'(d), (i == 3 || i == 4) ? 10'h0BF : 10'h0FF);
    end
    wrr(8'h60, 8'hFF);
    rdr(8'h60, d);
    chk(10'(d), 10'h000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_gain;
    wrr(8'h5B, 8'h76); wrr(8'h5D, 8'h00); wrr(8'h5C, 8'hA5); wrr(8'h5E, 8'h00);
    smp(8'h10, 8'h10, 8'h00, 1'b0, 1'b0);
    chk(10'(vo_v), 10'h001);
    chk(uo, 10'(16 * 118 / 128));
    chk(vo, 10'(16 * 165 / 128));
    wrr(8'h5B, 8'h00); wrr(8'h5C, 8'h00); wrr(8'h5E, 8'h80);
    smp(8'h10, 8'h10, 8'h00, 1'b0, 1'b0);
    chk(uo, 10'h000);
    chk(vo, 10'h3E0);
    $display("test gain done");
  endtask : t_gain
  task automatic t_level;
    wrr(8'h5D, 8'h3A); wrr(8'h5E, 8'h2E); wrr(8'h5F, 8'hC5);
    smp(8'h00, 8'h00, 8'h00, 1'b1, 1'b1);
    chk(10'(lvl), 10'h005);
    // smp ends just past an edge, so wait for the next one before driving again
    @(posedge clk);
    smp(8'h00, 8'h00, 8'h00, 1'b1, 1'b0);
    chk(10'(lvl), 10'h02E);
    @(posedge clk);
    smp(8'h00, 8'h00, 8'h00, 1'b0, 1'b0);
    chk(10'(lvl), 10'h03A);
    for (int i = 0; i < 4; i++) begin
      wrr(8'h5F, {2'(i), 6'h00});
      @(posedge clk) #1;
      chk(10'(xcr), 10'(i));
    end
    wrr(8'h5A, 8'h6B);
    smp(8'h00, 8'h00, 8'hC0, 1'b0, 1'b0);
    chk(10'(pho), 10'h02B);
    $display("test level and phase done");
  endtask : t_level
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // the tests take about a hundred cycles, so this only trips on a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_gain();
    t_level();
    complete_run();
  end
endmodule : tb
